// >>> design/vow_defs.svh
`ifndef VOW_DEFS_SVH
`define VOW_DEFS_SVH
// Register offsets
`define VOW_OFS_CTRL_C      8'h14
`define VOW_OFS_HSTART      8'h17
`define VOW_OFS_HEND        8'h18
`define VOW_OFS_VSTART      8'h19
`define VOW_OFS_VERTICAL_WINDOW_END        8'h1a
`define VOW_OFS_PDELAY      8'h1b
// Reset values
`define VOW_RST_CTRL_C      8'h00
`define VOW_RST_HSTART      8'h38
`define VOW_RST_HEND        8'hea
`define VOW_RST_VSTART      8'h03
`define VOW_RST_VERTICAL_WINDOW_END        8'h92
`define VOW_RST_PDELAY      8'h00
// Field positions in common_control_c
`define VOW_BIT_QCIF        5
`define VOW_BIT_LV_POL      3
// Frame timing in pixel clocks and lines
`define VOW_LINE_PIX_CIF    10'd480
`define VOW_LINE_PIX_QCIF   10'd240
`define VOW_FRAME_ROWS      8'd156
// Data path
`define VOW_PIX_W           8
`define VOW_FIFO_DEPTH      8
`endif

// >>> design/vow_pkg.sv
package vow_pkg;
   typedef logic [7:0] vow_byte_t;
   typedef enum logic [1:0] {
      VOW_RES_CIF  = 2'b01,
      VOW_RES_QCIF = 2'b10
   } vow_res_t;
endpackage : vow_pkg

// >>> design/vow_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module vow_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   assign in_ready  = (count_reg != DEPTH[AW:0]);
   assign out_valid = (count_reg != '0);
   assign out_data  = mem[rd_ptr_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule : vow_fifo
`default_nettype wire

// >>> design/vow_window.sv
// Summary of operation
// - Start count: two pixels CIF, one QCIF
// - Window edges from column and row counter compare
// - Reset defaults: 358-wide window, ending at column 234
// - Vertical counts are one scan line each
// - Pixel data delayed by register pixel clocks
// - Delay up to FF, later only
// - Delay leaves window position and size alone
// - Quarter bit selects 176x144 or 352x288 units
// - Polarity bit: clear high, set low
`include "vow_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module vow_window
   import vow_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   input  wire logic                  pixel_clk_pin,
   input  wire logic [`VOW_PIX_W-1:0] sensor_data,
   input  wire logic                  sensor_valid,
   output logic                       sensor_ready,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_write,
   input  wire logic                  reg_read,
   output logic [7:0]                 reg_rdata,
   output logic                       line_valid,
   output logic [`VOW_PIX_W-1:0]      pixel_data,
   output logic                       frame_sync
);
   vow_byte_t                   ctrl_c_reg;
   vow_byte_t                   hstart_reg;
   vow_byte_t                   hend_reg;
   vow_byte_t                   vstart_reg;
   vow_byte_t                   vertical_window_end_reg;
   vow_byte_t                   pdelay_reg;
   vow_byte_t                   rdata_reg;
   logic                        pclk_s1_reg;
   logic                        pclk_s2_reg;
   logic                        pclk_s3_reg;
   logic                        pix_en;
   logic                        pix_en_d_reg;
   logic [9:0]                  pix_cnt_reg;
   logic [9:0]                  line_last;
   logic [7:0]                  row_reg;
   vow_byte_t                   col_value;
   vow_res_t                    res_mode;
   logic                        in_window;
   logic                        lv_reg;
   logic                        fsync_reg;
   logic [`VOW_PIX_W-1:0]       delay_mem [256];
   logic [7:0]                  dly_wr_reg;
   logic [7:0]                  dly_rd_idx;
   logic [`VOW_PIX_W-1:0]       cur_pix;
   logic [`VOW_PIX_W-1:0]       pix_out_reg;
   logic [`VOW_PIX_W-1:0]       fifo_data;
   logic                        fifo_valid;

   function automatic logic in_range(input vow_byte_t v, input vow_byte_t lo, input vow_byte_t hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction : in_range

   // Pixel clock pin synchroniser and rising edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pclk_s1_reg <= 1'b0;
         pclk_s2_reg <= 1'b0;
         pclk_s3_reg <= 1'b0;
      end else begin
         pclk_s1_reg <= pixel_clk_pin;
         pclk_s2_reg <= pclk_s1_reg;
         pclk_s3_reg <= pclk_s2_reg;
      end
   end

   assign pix_en = pclk_s2_reg && !pclk_s3_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pix_en_d_reg <= 1'b0;
      end else begin
         pix_en_d_reg <= pix_en;
      end
   end

   // Register writes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_c_reg <= `VOW_RST_CTRL_C;
         hstart_reg <= `VOW_RST_HSTART;
         hend_reg   <= `VOW_RST_HEND;
         vstart_reg <= `VOW_RST_VSTART;
         vertical_window_end_reg   <= `VOW_RST_VERTICAL_WINDOW_END;
         pdelay_reg <= `VOW_RST_PDELAY;
      end else if (reg_write) begin
         if (reg_addr == `VOW_OFS_CTRL_C) begin
            ctrl_c_reg <= reg_wdata;
         end else if (reg_addr == `VOW_OFS_HSTART) begin
            hstart_reg <= reg_wdata;
         end else if (reg_addr == `VOW_OFS_HEND) begin
            hend_reg <= reg_wdata;
         end else if (reg_addr == `VOW_OFS_VSTART) begin
            vstart_reg <= reg_wdata;
         end else if (reg_addr == `VOW_OFS_VERTICAL_WINDOW_END) begin
            vertical_window_end_reg <= reg_wdata;
         end else if (reg_addr == `VOW_OFS_PDELAY) begin
            pdelay_reg <= reg_wdata;
         end
      end
   end

   // Register reads; unmapped offsets read zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= 8'h00;
      end else if (reg_read) begin
         if (reg_addr == `VOW_OFS_CTRL_C) begin
            rdata_reg <= ctrl_c_reg;
         end else if (reg_addr == `VOW_OFS_HSTART) begin
            rdata_reg <= hstart_reg;
         end else if (reg_addr == `VOW_OFS_HEND) begin
            rdata_reg <= hend_reg;
         end else if (reg_addr == `VOW_OFS_VSTART) begin
            rdata_reg <= vstart_reg;
         end else if (reg_addr == `VOW_OFS_VERTICAL_WINDOW_END) begin
            rdata_reg <= vertical_window_end_reg;
         end else if (reg_addr == `VOW_OFS_PDELAY) begin
            rdata_reg <= pdelay_reg;
         end else begin
            rdata_reg <= 8'h00;
         end
      end
   end

   assign res_mode  = ctrl_c_reg[`VOW_BIT_QCIF] ? VOW_RES_QCIF : VOW_RES_CIF;
   assign line_last = (res_mode == VOW_RES_QCIF) ? `VOW_LINE_PIX_QCIF - 10'd1 : `VOW_LINE_PIX_CIF - 10'd1;

   // Column counter unit: pixel pairs in CIF, single pixels in QCIF
   assign col_value = (res_mode == VOW_RES_QCIF) ? pix_cnt_reg[7:0] : pix_cnt_reg[8:1];

   // Pixel and row counters
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pix_cnt_reg <= 10'h000;
         row_reg     <= 8'h00;
      end else if (pix_en) begin
         if (pix_cnt_reg >= line_last) begin
            pix_cnt_reg <= 10'h000;
            // One count per scan line
            row_reg <= (row_reg == `VOW_FRAME_ROWS - 8'd1) ? 8'h00 : row_reg + 8'd1;
         end else begin
            pix_cnt_reg <= pix_cnt_reg + 10'd1;
         end
      end
   end

   assign in_window = in_range(row_reg, vstart_reg, vertical_window_end_reg)
                   && in_range(col_value, hstart_reg, hend_reg);

   // Line-valid and frame marker, one update per pixel clock
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lv_reg    <= 1'b0;
         fsync_reg <= 1'b0;
      end else if (pix_en) begin
         lv_reg    <= in_window ^ ctrl_c_reg[`VOW_BIT_LV_POL];
         fsync_reg <= (row_reg == 8'h00);
      end
   end

   // Sensor samples buffered, one drained per pixel clock
   vow_fifo #(
      .WIDTH (`VOW_PIX_W),
      .DEPTH (`VOW_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .arst_n    (arst_n),
      .in_data   (sensor_data),
      .in_valid  (sensor_valid),
      .in_ready  (sensor_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (pix_en)
   );

   // Underrun sends black
   assign cur_pix = fifo_valid ? fifo_data : '0;

   // Delay line: circular buffer read behind the write point
   assign dly_rd_idx = dly_wr_reg - pdelay_reg;

   always_ff @(posedge clk) begin
      if (pix_en) begin
         delay_mem[dly_wr_reg] <= cur_pix;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dly_wr_reg  <= 8'h00;
         pix_out_reg <= '0;
      end else if (pix_en) begin
         dly_wr_reg <= dly_wr_reg + 8'd1;
         // Zero delay bypasses the buffer
         pix_out_reg <= (pdelay_reg == 8'h00) ? cur_pix : delay_mem[dly_rd_idx];
      end
   end

   assign reg_rdata  = rdata_reg;
   assign line_valid = lv_reg;
   assign pixel_data = pix_out_reg;
   assign frame_sync = fsync_reg;

   // Line valid and pixel data change only right after a pixel clock edge
   lv_pixel_edge_a : assert property (@(posedge clk) disable iff (!arst_n)
      !pix_en_d_reg |-> $stable(lv_reg) && $stable(pix_out_reg))
      else $error("line valid or data moved without pixel edge");

   // Second synchroniser stage follows the first
   sync_chain_a : assert property (@(posedge clk) disable iff (!arst_n)
      pclk_s2_reg == $past(pclk_s1_reg))
      else $error("pixel clock synchroniser broken");

   pix_hold_a : assert property (@(posedge clk) disable iff (!arst_n)
      !pix_en |=> $stable(pix_cnt_reg) && $stable(row_reg))
      else $error("counters moved without pixel edge");

   line_wrap_a : assert property (@(posedge clk) disable iff (!arst_n)
      pix_en && pix_cnt_reg >= line_last |=> pix_cnt_reg == 10'h000)
      else $error("pixel counter did not wrap at line end");

   fsync_row_a : assert property (@(posedge clk) disable iff (!arst_n)
      pix_en |=> fsync_reg == ($past(row_reg) == 8'h00))
      else $error("frame marker not tied to first row");

   outside_cols_a : assert property (@(posedge clk) disable iff (!arst_n)
      pix_en && !in_range(col_value, hstart_reg, hend_reg) && !reg_write
      |=> lv_reg == ctrl_c_reg[`VOW_BIT_LV_POL])
      else $error("line valid active outside horizontal window");

   dly_step_a : assert property (@(posedge clk) disable iff (!arst_n)
      pix_en |=> dly_wr_reg == $past(dly_wr_reg) + 8'd1)
      else $error("delay line write point did not step");

   // Register port write and read paths
   write_lands_a : assert property (@(posedge clk) disable iff (!arst_n)
      reg_write && reg_addr == `VOW_OFS_PDELAY |=> pdelay_reg == $past(reg_wdata))
      else $error("delay register write lost");

   read_back_a : assert property (@(posedge clk) disable iff (!arst_n)
      reg_read && reg_addr == `VOW_OFS_HSTART |=> rdata_reg == $past(hstart_reg))
      else $error("start register read wrong");

   col_unit_a : assert property (@(posedge clk) disable iff (!arst_n)
      ctrl_c_reg[`VOW_BIT_QCIF] == 1'b0 |-> col_value == pix_cnt_reg[8:1])
      else $error("column unit wrong in full resolution");

   // Quarter resolution steps one column per pixel; the row counter steps one per line

   qcif_unit_a : assert property (@(posedge clk) disable iff (!arst_n)
      pix_en && ctrl_c_reg[`VOW_BIT_QCIF] && pix_cnt_reg < line_last |=> col_value == $past(col_value) + 8'd1)
      else $error("quarter resolution column not one pixel per count");

   row_step_a : assert property (@(posedge clk) disable iff (!arst_n)
      pix_en && pix_cnt_reg >= line_last && row_reg < `VOW_FRAME_ROWS - 8'd1 |=> row_reg == $past(row_reg) + 8'd1)
      else $error("row counter did not step one line");

   // Window checks skip edges where a write may move the bounds

   outside_rows_a : assert property (@(posedge clk) disable iff (!arst_n)
      pix_en && (row_reg < vstart_reg || row_reg > vertical_window_end_reg) && !reg_write
      |=> lv_reg == ctrl_c_reg[`VOW_BIT_LV_POL])
      else $error("line valid active outside vertical window");

   lv_polarity_a : assert property (@(posedge clk) disable iff (!arst_n)
      pix_en && in_window && !reg_write |=> lv_reg == !ctrl_c_reg[`VOW_BIT_LV_POL])
      else $error("line valid polarity wrong inside window");

   // Delay line read point and bypass; horizontal bounds held between writes

   zero_delay_a : assert property (@(posedge clk) disable iff (!arst_n)
      pix_en && pdelay_reg == 8'h00 |=> pix_out_reg == $past(cur_pix))
      else $error("zero delay did not pass current pixel");

   delay_read_a : assert property (@(posedge clk) disable iff (!arst_n)
      pix_en && pdelay_reg != 8'h00 |=> dly_wr_reg - $past(dly_rd_idx) == $past(pdelay_reg) + 8'd1)
      else $error("delay line read point not behind by setting");

   window_held_a : assert property (@(posedge clk) disable iff (!arst_n)
      !(reg_write && (reg_addr == `VOW_OFS_HSTART || reg_addr == `VOW_OFS_HEND))
      |=> $stable(hstart_reg) && $stable(hend_reg))
      else $error("horizontal window moved without a write");
endmodule : vow_window
`default_nettype wire

// >>> testbench/vow_capture_model.sv
`timescale 1ns/1ps
`default_nettype none
module vow_capture_model
   import vow_pkg::*;
(
   input  wire logic      pclk,
   input  wire logic      arst_n,
   input  wire logic      line_valid,
   input  wire vow_byte_t pixel_data,
   output int             run_len,
   output int             run_cnt,
   output vow_byte_t      first_pix
);
   int   cnt;
   logic act_q;
   // Captures only while line_valid is high; first pixel and length per line
   always @(posedge pclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt = 0;
         act_q = 1'b0;
         run_len = 0;
         run_cnt = 0;
         first_pix = 8'h00;
      end else begin
         if (line_valid === 1'b1) begin
            if (cnt == 0) first_pix = pixel_data;
            cnt++;
         end else if (act_q) begin
            run_len = cnt;
            run_cnt++;
            cnt = 0;
         end
         act_q = (line_valid === 1'b1);
      end
   end
endmodule : vow_capture_model
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
   import vow_pkg::*;
;
   logic      clk, arst_n, pclk, s_valid, s_ready, wr, rd_p, lv, fs;
   vow_byte_t s_data, addr, wdata, rdata, pix, first, f0, v;
   int        run_len, run_cnt, err_count, n_compared;
   vow_byte_t ofs [7] = '{8'h14, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c};
   vow_byte_t dfl [7] = '{8'h00, 8'h38, 8'hea, 8'h03, 8'h92, 8'h00, 8'h00};

   vow_window u_vow_window (.clk(clk), .arst_n(arst_n), .pixel_clk_pin(pclk), .sensor_data(s_data),
      .sensor_valid(s_valid), .sensor_ready(s_ready), .reg_addr(addr), .reg_wdata(wdata),
      .reg_write(wr), .reg_read(rd_p), .reg_rdata(rdata), .line_valid(lv), .pixel_data(pix),
      .frame_sync(fs));
   vow_capture_model u_vow_capture_model (.pclk(pclk), .arst_n(arst_n), .line_valid(lv),
      .pixel_data(pix), .run_len(run_len), .run_cnt(run_cnt), .first_pix(first));

   always #10 clk = ~clk;
   always #80 pclk = ~pclk;
   // Incrementing sample stream, advances only when taken
   always @(posedge clk) if (s_valid && s_ready) s_data <= #1 s_data + 8'h01;

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task wr_reg(input vow_byte_t a, input vow_byte_t d);
      @(posedge clk) #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk) #1;
      wr = 1'b0;
   endtask : wr_reg

   task rd_reg(input vow_byte_t a, output vow_byte_t d);
      @(posedge clk) #1;
      addr = a;
      rd_p = 1'b1;
      @(posedge clk) #1;
      rd_p = 1'b0;
      d = rdata;
   endtask : rd_reg

   task wait_runs(input int n);
      for (int i = 0; i < 40000 && run_cnt < n; i++) @(posedge clk);
      chk(16'(run_cnt), 16'(n));
   endtask : wait_runs

   task conclude;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude

   initial begin
      #1000000;
      err_count++;
      conclude();
   end

   initial begin
      clk = 0;
      pclk = 0;
      arst_n = 0;
      s_valid = 0;
      s_data = 8'h00;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 0;
      rd_p = 0;
      err_count = 0;
      n_compared = 0;
      repeat (20) @(posedge clk);
      #1 arst_n = 1;
      s_valid = 1;
      for (int i = 0; i < 7; i++) begin
         rd_reg(ofs[i], v);
         chk(16'(v), 16'(dfl[i]));
      end
      wr_reg(8'h1c, 8'h5a);
      rd_reg(8'h1c, v);
      chk(16'(v), 16'h0000);
      chk(16'(s_ready), 16'h0000);
      chk(16'(fs), 16'h0001);
      $display("test defaults done");
      // Quarter mode, narrow window on rows 3..4
      wr_reg(8'h14, 8'h20);
      wr_reg(8'h17, 8'h40);
      wr_reg(8'h18, 8'h44);
      wr_reg(8'h1a, 8'h04);
      rd_reg(8'h17, v);
      chk(16'(v), 16'h0040);
      wait_runs(1);
      chk(16'(run_len), 16'd5);
      f0 = first;
      wr_reg(8'h1b, 8'hff);
      wait_runs(2);
      chk(16'(run_len), 16'd5);
      chk(16'(first), 16'(vow_byte_t'(f0 + 8'd240 - 8'hff)));
      $display("test quarter window and delay done");
      // Full mode, two counts on rows 6..7
      wr_reg(8'h1b, 8'h00);
      wr_reg(8'h14, 8'h00);
      wr_reg(8'h18, 8'h41);
      wr_reg(8'h1a, 8'h07);
      wr_reg(8'h19, 8'h06);
      wait_runs(3);
      chk(16'(run_len), 16'd4);
      chk(16'(fs), 16'h0000);
      $display("test full window done");
      wr_reg(8'h14, 8'h08);
      repeat (40) @(posedge clk);
      chk(16'(lv), 16'h0001);
      $display("test polarity done");
      conclude();
   end
endmodule : testbench
`default_nettype wire
